// file: rtl/hia_flags.sv
/*
  Pending flag store with clear-on-read.
  Assumes rd_clr is a one-cycle strobe from the register core.
*/
`timescale 1ns/1ns
`include "hia_regs.svh"
module hia_flags
  import hia_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Carrier
  hia_if.flg       c
);
  logic [`HIA_FW-1:0] flags_reg;  // Latched events
  logic [`HIA_FW-1:0] flags_next; // Next value

  // Clear on read, then OR in this cycle's events so they survive
  always_comb begin
    flags_next = c.rd_clr ? `HIA_RST_FLAGS : flags_reg; // RQ5
    flags_next = flags_next | c.ev; // RQ4 RQ11
  end

  // Register only
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_reg <= `HIA_RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end

  assign c.flags = flags_reg;
endmodule : hia_flags

// file: rtl/hia_if.sv
/*
  Internal carrier between the register core, the flag store and the pin
  driver. Assumes all three sit on the same clock.
*/
`timescale 1ns/1ns
`include "hia_regs.svh"
interface hia_if;
  logic [`HIA_FW-1:0] ev;        // Event strobes, one per flag
  logic               rd_clr;    // Flag register read accepted
  logic [`HIA_FW-1:0] flags;     // Pending flags
  logic [`HIA_FW-1:0] mask;      // Per-flag enables
  logic               int_en;    // Global output enable
  logic               push_pull; // Drive mode select
  logic               pin_out;   // Pin output value
  logic               pin_oe_n;  // Pin output enable, low drives
  modport core (output ev, rd_clr, mask, int_en, push_pull, input flags, pin_out, pin_oe_n);
  modport flg  (input ev, rd_clr, output flags);
  modport drv  (input flags, mask, int_en, push_pull, output pin_out, pin_oe_n);
endinterface : hia_if

// file: rtl/hia_pin.sv
/*
  Request pin driver: masks flags, applies the output enable and the
  open-drain or push-pull mode. Assumes an external pull-up on the pin.
*/
`timescale 1ns/1ns
`include "hia_regs.svh"
module hia_pin
  import hia_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Carrier
  hia_if.drv       c
);
  logic req;       // Any masked flag pending
  logic out_reg;   // Pin value
  logic out_next;
  logic oe_n_reg;  // Pin enable, low drives
  logic oe_n_next;

  // Work out pin drive; disabled means released in either mode
  always_comb begin
    req       = |(c.flags & c.mask); // RQ3
    out_next  = 1'b1;
    oe_n_next = 1'b1; // RQ1
    if (c.int_en) begin
      if (c.push_pull) begin
        out_next  = ~req; // RQ7
        oe_n_next = 1'b0;
      end else begin
        out_next  = 1'b0; // RQ6
        oe_n_next = ~req; // RQ2
      end
    end
  end

  // Register only, released after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_reg  <= 1'b1;
      oe_n_reg <= 1'b1;
    end else begin
      out_reg  <= out_next;
      oe_n_reg <= oe_n_next;
    end
  end

  assign c.pin_out  = out_reg;
  assign c.pin_oe_n = oe_n_reg;
endmodule : hia_pin

// file: rtl/hia_pkg.sv
/*
  Types shared by the interrupt aggregator modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package hia_pkg;
  // Register selected by a bus address
  typedef enum logic [2:0] {SEL_FLAGS, SEL_MASK, SEL_EN, SEL_PINCFG, SEL_STATUS, SEL_NONE} hia_sel_e;
  // Write channel state
  typedef enum logic [0:0] {WR_IDLE, WR_RESP} hia_wr_state_e;
  // Read channel state
  typedef enum logic [0:0] {RD_IDLE, RD_RESP} hia_rd_state_e;
endpackage : hia_pkg

// file: rtl/hia_regs.svh
/*
  Register map, field positions, reset values and bus codes of the host
  interrupt aggregator. Assumes inclusion by bare name from rtl/.
*/
// ************************************************************
// Function
// RQ1: Output enable low leaves request pin undriven
// RQ2: Enabled, any masked pending flag pulls low
// RQ3: Mask one passes flag, zero blocks it
// RQ4: Each source sets its flag, mask-independent
// RQ5: Flags readable anytime, read clears them all
// RQ6: Request pin is open-drain after reset
// RQ7: Pin config bit selects push-pull drive
// RQ8: Flag bits 7,6,5,4,3,1 source map
// RQ9: Bit 2 set on touch tag change
// RQ10: Bit 0 set on display list swap
// RQ11: Event in clearing read cycle is kept
// ************************************************************
`ifndef HIA_REGS_SVH
`define HIA_REGS_SVH

// Bus and flag widths
`define HIA_AW            8
`define HIA_DW            32
`define HIA_FW            8

// Byte offsets of the registers
`define HIA_OFS_FLAGS     8'h00
`define HIA_OFS_MASK      8'h04
`define HIA_OFS_INT_EN    8'h08
`define HIA_OFS_PINCFG    8'h0c
`define HIA_OFS_STATUS    8'h10

// Field positions
`define HIA_BIT_CONV      7
`define HIA_BIT_COMMAND_QUEUE_FLAG_EVENT   6
`define HIA_BIT_COMMAND_QUEUE_EMPTY_EVENT  5
`define HIA_BIT_PLAYBACK  4
`define HIA_BIT_SOUND     3
`define HIA_BIT_TAG       2
`define HIA_BIT_TOUCH     1
`define HIA_BIT_SWAP      0
`define HIA_BIT_EN        0
`define HIA_BIT_PP        0
`define HIA_BIT_ST_REQ    0
`define HIA_BIT_ST_LOW    1

// Reset values
`define HIA_RST_FLAGS     8'h00
`define HIA_RST_MASK      8'h00
`define HIA_RST_EN        1'h0
`define HIA_RST_PP        1'h0

// Response codes
`define HIA_RESP_OKAY     2'h0
`define HIA_RESP_SLVERR   2'h2

`endif

// file: rtl/hia_top.sv
/*
  Host interrupt aggregator top: AXI4-Lite register slave, event inputs
  and the active-low request pin as two signals.
  Assumes one clock, synchronous active-low reset, event inputs already
  synchronous to aclk, and an external pull-up on the request pin.
*/
// The placing of the registers and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "hia_regs.svh"
module hia_top
  import hia_pkg::*;
(
  // ************************************************************
  // Clock and reset
  // ************************************************************
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  // ************************************************************
  // AXI4-Lite write address and data
  // ************************************************************
  input  wire logic                 s_axil_awvalid,
  output logic                      s_axil_awready,
  input  wire logic [`HIA_AW-1:0]   s_axil_awaddr,
  input  wire logic                 s_axil_wvalid,
  output logic                      s_axil_wready,
  input  wire logic [`HIA_DW-1:0]   s_axil_wdata,
  input  wire logic [3:0]           s_axil_wstrb,
  // ************************************************************
  // AXI4-Lite write response
  // ************************************************************
  output logic                      s_axil_bvalid,
  input  wire logic                 s_axil_bready,
  output logic [1:0]                s_axil_bresp,
  // ************************************************************
  // AXI4-Lite read
  // ************************************************************
  input  wire logic                 s_axil_arvalid,
  output logic                      s_axil_arready,
  input  wire logic [`HIA_AW-1:0]   s_axil_araddr,
  output logic                      s_axil_rvalid,
  input  wire logic                 s_axil_rready,
  output logic [`HIA_DW-1:0]        s_axil_rdata,
  output logic [1:0]                s_axil_rresp,
  // ************************************************************
  // Event sources, one-cycle strobes
  // ************************************************************
  input  wire logic                 conversion_done_event,
  input  wire logic                 command_queue_flag_event,
  input  wire logic                 command_queue_empty_event,
  input  wire logic                 playback_end_event,
  input  wire logic                 sound_end_event,
  input  wire logic                 tag_change_event,
  input  wire logic                 touch_event,
  input  wire logic                 swap_event,
  // ************************************************************
  // Request pin, active low
  // ************************************************************
  output logic                      irq_n,
  output logic                      irq_n_oe_n
);

  // ************************************************************
  // Address decode
  // ************************************************************

  // Shared by the read and write paths
  function automatic hia_sel_e decode(input logic [`HIA_AW-1:0] a);
    case (a)
      `HIA_OFS_FLAGS:  decode = SEL_FLAGS;
      `HIA_OFS_MASK:   decode = SEL_MASK;
      `HIA_OFS_INT_EN: decode = SEL_EN;
      `HIA_OFS_PINCFG: decode = SEL_PINCFG;
      `HIA_OFS_STATUS: decode = SEL_STATUS;
      default:         decode = SEL_NONE;
    endcase
  endfunction : decode

  // ************************************************************
  // Declarations
  // ************************************************************

  hia_if u_if ();                          // Internal carrier

  // Write path state
  hia_wr_state_e        wr_state_reg;      // Write channel state
  hia_wr_state_e        wr_state_next;
  logic                 aw_held_reg;       // Address taken, waiting data
  logic                 aw_held_next;
  logic                 w_held_reg;        // Data taken, waiting address
  logic                 w_held_next;
  logic [`HIA_AW-1:0]   awaddr_reg;        // Captured write address
  logic [`HIA_AW-1:0]   awaddr_next;
  logic [`HIA_FW-1:0]   wdata_reg;         // Captured low byte
  logic [`HIA_FW-1:0]   wdata_next;
  logic                 wstrb0_reg;        // Low lane strobe
  logic                 wstrb0_next;
  logic                 awready_reg;       // Address ready
  logic                 awready_next;
  logic                 wready_reg;        // Data ready
  logic                 wready_next;
  logic                 bvalid_reg;        // Response valid
  logic                 bvalid_next;
  logic [1:0]           bresp_reg;         // Response code
  logic [1:0]           bresp_next;
  logic                 aw_take;           // Address handshake
  logic                 w_take;            // Data handshake
  hia_sel_e             wsel;              // Decoded write target

  // Software settings, part of the write group
  logic [`HIA_FW-1:0]   mask_reg;          // Per-flag enables
  logic [`HIA_FW-1:0]   mask_next;
  logic                 int_en_reg;        // Global output enable
  logic                 int_en_next;
  logic                 push_pull_reg;     // Pin drive mode
  logic                 push_pull_next;

  // Read path state
  hia_rd_state_e        rd_state_reg;      // Read channel state
  hia_rd_state_e        rd_state_next;
  logic                 arready_reg;       // Address ready
  logic                 arready_next;
  logic                 rvalid_reg;        // Read data valid
  logic                 rvalid_next;
  logic [`HIA_DW-1:0]   rdata_reg;         // Read data
  logic [`HIA_DW-1:0]   rdata_next;
  logic [1:0]           rresp_reg;         // Read response code
  logic [1:0]           rresp_next;
  logic                 rd_clr;            // Clear strobe to flag store
  hia_sel_e             rsel;              // Decoded read target

  // ************************************************************
  // Event gathering
  // ************************************************************

  // Each source owns one flag position
  always_comb begin
    u_if.ev                     = `HIA_RST_FLAGS;
    u_if.ev[`HIA_BIT_CONV]      = conversion_done_event;      // RQ8
    u_if.ev[`HIA_BIT_COMMAND_QUEUE_FLAG_EVENT]   = command_queue_flag_event;   // RQ8
    u_if.ev[`HIA_BIT_COMMAND_QUEUE_EMPTY_EVENT]  = command_queue_empty_event;  // RQ8
    u_if.ev[`HIA_BIT_PLAYBACK]  = playback_end_event;         // RQ8
    u_if.ev[`HIA_BIT_SOUND]     = sound_end_event;            // RQ8
    u_if.ev[`HIA_BIT_TAG]       = tag_change_event;           // RQ9
    u_if.ev[`HIA_BIT_TOUCH]     = touch_event;                // RQ8
    u_if.ev[`HIA_BIT_SWAP]      = swap_event;                 // RQ10
  end

  // Settings to the pin driver, clear strobe to the flag store
  assign u_if.mask      = mask_reg;
  assign u_if.int_en    = int_en_reg;
  assign u_if.push_pull = push_pull_reg;
  assign u_if.rd_clr    = rd_clr;

  // ************************************************************
  // Write path
  // ************************************************************

  // Address and data may arrive in either order; one write at a time.
  // Both readies fall once their item is held so nothing is overwritten.
  always_comb begin
    wr_state_next  = wr_state_reg;
    aw_held_next   = aw_held_reg;
    w_held_next    = w_held_reg;
    awaddr_next    = awaddr_reg;
    wdata_next     = wdata_reg;
    wstrb0_next    = wstrb0_reg;
    bvalid_next    = bvalid_reg;
    bresp_next     = bresp_reg;
    mask_next      = mask_reg;
    int_en_next    = int_en_reg;
    push_pull_next = push_pull_reg;
    wsel           = SEL_NONE;
    aw_take        = s_axil_awvalid && awready_reg;
    w_take         = s_axil_wvalid && wready_reg;
    // Capture whichever halves arrive
    if (aw_take) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axil_awaddr;
    end
    if (w_take) begin
      w_held_next = 1'b1;
      wdata_next  = s_axil_wdata[`HIA_FW-1:0];
      wstrb0_next = s_axil_wstrb[0];
    end
    case (wr_state_reg)
      // Commit as soon as both halves are in
      WR_IDLE: begin
        if (aw_held_next && w_held_next) begin
          wsel         = decode(awaddr_next);
          bresp_next   = `HIA_RESP_OKAY;
          aw_held_next = 1'b0;
          w_held_next  = 1'b0;
          bvalid_next  = 1'b1;
          wr_state_next = WR_RESP;
          case (wsel)
            // Mask bits gate flags onto the pin
            SEL_MASK:   mask_next      = wstrb0_next ? wdata_next : mask_reg; // RQ3
            // Global output enable
            SEL_EN:     int_en_next    = wstrb0_next ? wdata_next[`HIA_BIT_EN] : int_en_reg; // RQ1 RQ2
            // Drive mode select
            SEL_PINCFG: push_pull_next = wstrb0_next ? wdata_next[`HIA_BIT_PP] : push_pull_reg; // RQ7
            // Read-only registers ignore writes without error
            SEL_FLAGS, SEL_STATUS: begin
              bresp_next = `HIA_RESP_OKAY;
            end
            // Unmapped address
            default: begin
              bresp_next = `HIA_RESP_SLVERR;
            end
          endcase
        end
      end
      // Hold the response until the master takes it
      WR_RESP: begin
        if (s_axil_bready) begin
          bvalid_next   = 1'b0;
          wr_state_next = WR_IDLE;
        end
      end
      default: begin
        wr_state_next = WR_IDLE;
      end
    endcase
    awready_next = !aw_held_next && (wr_state_next == WR_IDLE);
    wready_next  = !w_held_next && (wr_state_next == WR_IDLE);
  end

  // Register the write group; reset leaves the pin open-drain and off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg  <= WR_IDLE;
      aw_held_reg   <= 1'b0;
      w_held_reg    <= 1'b0;
      awaddr_reg    <= {`HIA_AW{1'b0}};
      wdata_reg     <= `HIA_RST_FLAGS;
      wstrb0_reg    <= 1'b0;
      awready_reg   <= 1'b0;
      wready_reg    <= 1'b0;
      bvalid_reg    <= 1'b0;
      bresp_reg     <= `HIA_RESP_OKAY;
      mask_reg      <= `HIA_RST_MASK;
      int_en_reg    <= `HIA_RST_EN;
      push_pull_reg <= `HIA_RST_PP; // RQ6
    end else begin
      wr_state_reg  <= wr_state_next;
      aw_held_reg   <= aw_held_next;
      w_held_reg    <= w_held_next;
      awaddr_reg    <= awaddr_next;
      wdata_reg     <= wdata_next;
      wstrb0_reg    <= wstrb0_next;
      awready_reg   <= awready_next;
      wready_reg    <= wready_next;
      bvalid_reg    <= bvalid_next;
      bresp_reg     <= bresp_next;
      mask_reg      <= mask_next;
      int_en_reg    <= int_en_next;
      push_pull_reg <= push_pull_next;
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************

  // Data is sampled at address acceptance; the flag read clears the
  // store on that same edge, so the host sees the pre-clear value.
  always_comb begin
    rd_state_next = rd_state_reg;
    rvalid_next   = rvalid_reg;
    rdata_next    = rdata_reg;
    rresp_next    = rresp_reg;
    rd_clr        = 1'b0;
    rsel          = SEL_NONE;
    case (rd_state_reg)
      // Accept one address and build the answer
      RD_IDLE: begin
        if (s_axil_arvalid && arready_reg) begin
          rsel          = decode(s_axil_araddr);
          rdata_next    = {`HIA_DW{1'b0}};
          rresp_next    = `HIA_RESP_OKAY;
          rvalid_next   = 1'b1;
          rd_state_next = RD_RESP;
          case (rsel)
            // Pending flags, cleared by this read
            SEL_FLAGS: begin
              rdata_next[`HIA_FW-1:0] = u_if.flags; // RQ5
              rd_clr = 1'b1; // RQ5
            end
            SEL_MASK:   rdata_next[`HIA_FW-1:0] = mask_reg;
            SEL_EN:     rdata_next[`HIA_BIT_EN] = int_en_reg;
            SEL_PINCFG: rdata_next[`HIA_BIT_PP] = push_pull_reg;
            // Live view of the request and the pin
            SEL_STATUS: begin
              rdata_next[`HIA_BIT_ST_REQ] = |(u_if.flags & mask_reg);
              rdata_next[`HIA_BIT_ST_LOW] = !u_if.pin_oe_n && !u_if.pin_out;
            end
            // Unmapped address reads zero with an error
            default: begin
              rresp_next = `HIA_RESP_SLVERR;
            end
          endcase
        end
      end
      // Hold data until the master takes it
      RD_RESP: begin
        if (s_axil_rready) begin
          rvalid_next   = 1'b0;
          rd_state_next = RD_IDLE;
        end
      end
      default: begin
        rd_state_next = RD_IDLE;
      end
    endcase
    arready_next = (rd_state_next == RD_IDLE);
  end

  // Register the read group
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= RD_IDLE;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
      rdata_reg    <= {`HIA_DW{1'b0}};
      rresp_reg    <= `HIA_RESP_OKAY;
    end else begin
      rd_state_reg <= rd_state_next;
      arready_reg  <= arready_next;
      rvalid_reg   <= rvalid_next;
      rdata_reg    <= rdata_next;
      rresp_reg    <= rresp_next;
    end
  end

  // ************************************************************
  // Flag store and pin driver
  // ************************************************************

  // Flags latch events and clear on read
  hia_flags u_flags (
    .aclk    (aclk),
    .aresetn (aresetn),
    .c       (u_if.flg)
  );

  // Masking, enable and drive mode
  hia_pin u_pin (
    .aclk    (aclk),
    .aresetn (aresetn),
    .c       (u_if.drv)
  );

  // ************************************************************
  // Outputs
  // ************************************************************

  assign s_axil_awready = awready_reg;
  assign s_axil_wready  = wready_reg;
  assign s_axil_bvalid  = bvalid_reg;
  assign s_axil_bresp   = bresp_reg;
  assign s_axil_arready = arready_reg;
  assign s_axil_rvalid  = rvalid_reg;
  assign s_axil_rdata   = rdata_reg;
  assign s_axil_rresp   = rresp_reg;
  assign irq_n          = u_if.pin_out;   // RQ1 RQ2
  assign irq_n_oe_n     = u_if.pin_oe_n;  // RQ1 RQ6

endmodule : hia_top

// file: sim/hia_assertions.sv
/* Port checker of the aggregator top.
   Assumes a write offers address and data together. */
`timescale 1ns/1ns
`include "hia_regs.svh"
module hia_assertions (
  // Clock and reset
  input wire logic               aclk,
  input wire logic               aresetn,
  // Bus
  input wire logic               s_axil_awvalid,
  input wire logic               s_axil_awready,
  input wire logic [`HIA_AW-1:0] s_axil_awaddr,
  input wire logic               s_axil_wvalid,
  input wire logic               s_axil_wready,
  input wire logic [`HIA_DW-1:0] s_axil_wdata,
  input wire logic               s_axil_bvalid,
  input wire logic               s_axil_arvalid,
  input wire logic               s_axil_arready,
  input wire logic               s_axil_rvalid,
  input wire logic               s_axil_rready,
  input wire logic [`HIA_DW-1:0] s_axil_rdata,
  // Events
  input wire logic               conversion_done_event,
  input wire logic               command_queue_flag_event,
  input wire logic               command_queue_empty_event,
  input wire logic               playback_end_event,
  input wire logic               sound_end_event,
  input wire logic               tag_change_event,
  input wire logic               touch_event,
  input wire logic               swap_event,
  // Pin
  input wire logic               irq_n,
  input wire logic               irq_n_oe_n
);
  // Shadow of the settings, tracked from accepted writes
  logic [7:0] msk_reg;
  logic       en_reg;
  logic       pp_reg;
  wire        wtake = s_axil_awvalid & s_axil_awready & s_axil_wvalid & s_axil_wready;
  wire  [7:0] ev = {conversion_done_event, command_queue_flag_event, command_queue_empty_event,
                    playback_end_event, sound_end_event, tag_change_event, touch_event, swap_event};
  wire        pin = irq_n_oe_n ? 1'b1 : irq_n;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      msk_reg <= 8'h00;
      en_reg  <= 1'b0;
      pp_reg  <= 1'b0;
    end else if (wtake) begin
      if (s_axil_awaddr == `HIA_OFS_MASK) msk_reg <= s_axil_wdata[7:0];
      if (s_axil_awaddr == `HIA_OFS_INT_EN) en_reg <= s_axil_wdata[0];
      if (s_axil_awaddr == `HIA_OFS_PINCFG) pp_reg <= s_axil_wdata[0];
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  chk_rst_pin_free: assert property ($rose(aresetn) |-> irq_n_oe_n && irq_n)
    else $error("pin not released after reset");
  chk_od_low_only: assert property (!pp_reg && $past(!pp_reg) |-> irq_n_oe_n || !irq_n)
    else $error("open-drain pin driven high");
  chk_off_releases: assert property (!en_reg && $past(!en_reg) |-> irq_n_oe_n)
    else $error("pin driven while disabled");
  chk_pp_drives: assert property (en_reg && pp_reg && $past(en_reg && pp_reg) |-> !irq_n_oe_n)
    else $error("push-pull pin not driven");
  chk_event_pin: assert property (en_reg && |(ev & msk_reg) |-> ##2 !pin)
    else $error("unmasked event did not pull pin low");
  chk_rd_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid && !s_axil_arready)
    else $error("read not answered");
  chk_rd_hold: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped");
  chk_wr_answer: assert property (wtake |=> s_axil_bvalid && !s_axil_awready)
    else $error("write not answered");
endmodule : hia_assertions
bind hia_top hia_assertions u_chk (.*);

// file: sim/hia_host_model.sv
/* Host side of the request line: external pull-up resolves the pin.
   Assumes the device drives only while its enable is low. */
`timescale 1ns/1ns
module hia_host_model (
  // Pin from the device
  input  wire logic irq_n,
  input  wire logic irq_n_oe_n,
  // Line level seen by the host
  output logic      pin_level
);
  // A released line floats up, never holds the last driven value
  assign pin_level = irq_n_oe_n ? 1'b1 : irq_n;
endmodule : hia_host_model

// file: sim/host_interrupt_aggregator_bench.sv
/* Self-checking bench of the aggregator top.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
`include "hia_regs.svh"
module host_interrupt_aggregator_bench;
  // Ordinary case: event, mask, enable, push-pull, expected line
  typedef struct {logic [7:0] ev; logic [7:0] m; logic en; logic pp; logic pin;} hia_row_s;
  hia_row_s rows [8] = '{'{8'h80, 8'h80, 1, 0, 0}, '{8'h40, 8'h00, 1, 0, 1}, '{8'h20, 8'hff, 0, 0, 1},
    '{8'h10, 8'h10, 1, 1, 0}, '{8'h08, 8'hf7, 1, 1, 1}, '{8'h04, 8'h04, 1, 0, 0},
    '{8'h02, 8'h02, 0, 1, 1}, '{8'h01, 8'h01, 1, 0, 0}};
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00, ev = 8'h00;
  logic [31:0] wd = 32'h0;
  logic        awr, wrdy, bv, arr, rv, irq, oen, pin;
  logic [1:0]  br, rr;
  logic [31:0] rdat;
  int          err_total = 0;
  int          n_checks = 0;
  always #50 aclk = ~aclk;
  hia_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axil_awvalid(awv), .s_axil_awready(awr),
    .s_axil_awaddr(awa), .s_axil_wvalid(wv), .s_axil_wready(wrdy), .s_axil_wdata(wd),
    .s_axil_wstrb(4'hf), .s_axil_bvalid(bv), .s_axil_bready(bre), .s_axil_bresp(br),
    .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_araddr(ara), .s_axil_rvalid(rv),
    .s_axil_rready(rre), .s_axil_rdata(rdat), .s_axil_rresp(rr),
    .conversion_done_event(ev[7]), .command_queue_flag_event(ev[6]), .command_queue_empty_event(ev[5]),
    .playback_end_event(ev[4]), .sound_end_event(ev[3]), .tag_change_event(ev[2]),
    .touch_event(ev[1]), .swap_event(ev[0]), .irq_n(irq), .irq_n_oe_n(oen));
  hia_host_model u_host (.irq_n(irq), .irq_n_oe_n(oen), .pin_level(pin));
  // Compare and count
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
    @(posedge aclk);
    awv <= 1'b1;
    wv  <= 1'b1;
    awa <= a;
    wd  <= v;
    bre <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (!awr);
        awv <= 1'b0;
      end
      begin
        do @(posedge aclk); while (!wrdy);
        wv <= 1'b0;
      end
    join
    while (!bv) @(posedge aclk);
    bre <= 1'b0;
    chk(br, er);
  endtask : wr
  // Bus read; ready raised late so the slave must hold its answer
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    arv <= 1'b1;
    ara <= a;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    do @(posedge aclk); while (!rv);
    rre <= 1'b1;
    @(posedge aclk);
    rre <= 1'b0;
    chk(rdat, e);
    chk(rr, er);
  endtask : rd
  // One-cycle event strobe
  task automatic pulse(input logic [7:0] v);
    @(posedge aclk);
    ev <= v;
    @(posedge aclk);
    ev <= 8'h00;
  endtask : pulse
  // Reset held for twelve edges
  task automatic rst();
    aresetn <= 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  // Verdict
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    err_total++;
    summarize();
  end
  initial begin
    rst();
    for (int a = 0; a <= 16; a += 4) rd(a[7:0], 32'h0, `HIA_RESP_OKAY);
    wr(8'h20, 32'hff, `HIA_RESP_SLVERR);
    rd(`HIA_OFS_MASK, 32'h0, `HIA_RESP_OKAY);
    $display("reset values done");
    foreach (rows[i]) begin
      wr(`HIA_OFS_MASK, {24'h0, rows[i].m}, `HIA_RESP_OKAY);
      wr(`HIA_OFS_INT_EN, {31'h0, rows[i].en}, `HIA_RESP_OKAY);
      wr(`HIA_OFS_PINCFG, {31'h0, rows[i].pp}, `HIA_RESP_OKAY);
      pulse(rows[i].ev);
      repeat (2) @(posedge aclk);
      #1 chk(pin, rows[i].pin);
      rd(`HIA_OFS_STATUS, {30'h0, !rows[i].pin, |(rows[i].ev & rows[i].m)}, `HIA_RESP_OKAY);
      rd(`HIA_OFS_FLAGS, rows[i].ev, `HIA_RESP_OKAY);
      rd(`HIA_OFS_FLAGS, 32'h0, `HIA_RESP_OKAY);
      repeat (2) @(posedge aclk);
      #1 chk(pin, 1'b1);
      $display("row %0d done", i);
    end
    pulse(8'hff);
    rd(`HIA_OFS_FLAGS, 32'hff, `HIA_RESP_OKAY);
    rd(`HIA_OFS_FLAGS, 32'h0, `HIA_RESP_OKAY);
    // Event held across the clearing read must survive it
    @(posedge aclk);
    ev <= 8'h08;
    rd(`HIA_OFS_FLAGS, 32'h08, `HIA_RESP_OKAY);
    ev <= 8'h00;
    rd(`HIA_OFS_FLAGS, 32'h08, `HIA_RESP_OKAY);
    rd(`HIA_OFS_FLAGS, 32'h0, `HIA_RESP_OKAY);
    $display("clear race done");
    wr(`HIA_OFS_MASK, 32'hff, `HIA_RESP_OKAY);
    wr(`HIA_OFS_INT_EN, 32'h1, `HIA_RESP_OKAY);
    pulse(8'h01);
    rst();
    rd(`HIA_OFS_INT_EN, 32'h0, `HIA_RESP_OKAY);
    rd(`HIA_OFS_FLAGS, 32'h0, `HIA_RESP_OKAY);
    chk(pin, 1'b1);
    $display("second reset done");
    summarize();
  end
endmodule : host_interrupt_aggregator_bench
